// File: logic/dvc_pkg.sv
// dvc_pkg: port map, field positions, codes and reset values
// of the drawing engine vector, colour and mask register front end.
// assumes a 16-bit host I/O space with even word addresses.
package dvc_pkg;

    // host I/O port addresses (word base, odd byte is base + 1)
    localparam logic [15:0] DVC_ADDR_CMD   = 16'h9AE8;
    localparam logic [15:0] DVC_ADDR_VEC   = 16'h9EE8;
    localparam logic [15:0] DVC_ADDR_BG    = 16'hA2E8;
    localparam logic [15:0] DVC_ADDR_FG    = 16'hA6E8;
    localparam logic [15:0] DVC_ADDR_WMASK = 16'hAAE8;
    localparam logic [15:0] DVC_ADDR_RMASK = 16'hAEE8;

    // draw command register fields
    localparam int DVC_CMD_CODE_LSB  = 13;
    localparam int DVC_CMD_ORDER_BIT = 12;
    localparam int DVC_CMD_WORD_BIT  = 9;
    localparam int DVC_CMD_PXEN_BIT  = 8;

    // command codes
    localparam logic [2:0] DVC_NO_OP_COMMAND     = 3'h0;
    localparam logic [2:0] DVC_CMD_LINE    = 3'h1;
    localparam logic [2:0] DVC_CMD_XRECT   = 3'h2;
    localparam logic [2:0] DVC_CMD_YRECT   = 3'h3;
    localparam logic [2:0] DVC_CMD_FASTY   = 3'h4;
    localparam logic [2:0] DVC_CMD_OUTLINE = 3'h5;
    localparam logic [2:0] DVC_CMD_COPY    = 3'h6;
    localparam logic [2:0] DVC_CMD_ILLEGAL = 3'h7;

    // short vector byte fields
    localparam int DVC_VEC_LEN_LSB  = 0;
    localparam int DVC_VEC_MARK_BIT = 4;
    localparam int DVC_VEC_DIR_LSB  = 5;

    // pixel depth codes
    localparam logic [1:0] DVC_DEPTH_4  = 2'h0;
    localparam logic [1:0] DVC_DEPTH_8  = 2'h1;
    localparam logic [1:0] DVC_DEPTH_16 = 2'h2;
    localparam logic [1:0] DVC_DEPTH_32 = 2'h3;

    // variable-depth register slots
    localparam int DVC_NUM_VDR = 4;
    localparam int DVC_VDR_BG  = 0;
    localparam int DVC_VDR_FG  = 1;
    localparam int DVC_VDR_WM  = 2;
    localparam int DVC_VDR_RM  = 3;

    // reset values
    localparam logic [31:0] DVC_VDR_RESET = 32'h0;
    localparam logic [2:0]  DVC_CMD_RESET = 3'h0;
    localparam logic [15:0] DVC_VEC_RESET = 16'h0;
    localparam logic [1:0]  DVC_LANE_A    = 2'h0;

endpackage

// File: logic/dvc_depth_reg.sv
// dvc_depth_reg: one variable-depth colour or mask register with its own
// modulo-n byte lane counter. assumes wr_in and clr_in are one-cycle pulses.
`timescale 1ns/1ps
module dvc_depth_reg
    import dvc_pkg::*;
(
    input  wire logic        clk_in,    // engine clock
    input  wire logic        resetn_in, // async reset, active low
    input  wire logic        clr_in,    // counter clear pulse
    input  wire logic        wr_in,     // byte write pulse
    input  wire logic [7:0]  byte_in,   // byte written
    input  wire logic [1:0]  depth_in,  // pixel depth code
    output logic      [31:0] value_out, // lanes D..A
    output logic      [1:0]  lane_out   // next lane to load
);
    logic [31:0] value_ff;
    logic [31:0] nxt_value;
    logic [1:0]  lane_ff;
    logic [1:0]  nxt_lane;

    always_comb begin
        nxt_value = value_ff;
        nxt_lane  = lane_ff;
        if (wr_in) begin
            nxt_value[{lane_ff, 3'b000} +: 8] = byte_in;
            case (depth_in)
                DVC_DEPTH_16: nxt_lane = {1'b0, ~lane_ff[0]};
                DVC_DEPTH_32: nxt_lane = 2'(lane_ff + 2'h1);
                default:      nxt_lane = DVC_LANE_A;
            endcase
        end
        // a clear in the same cycle as a write still stores the byte
        if (clr_in) begin
            nxt_lane = DVC_LANE_A;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            value_ff <= DVC_VDR_RESET;
            lane_ff  <= DVC_LANE_A;
        end else begin
            value_ff <= nxt_value;
            lane_ff  <= nxt_lane;
        end
    end

    assign value_out = value_ff;
    assign lane_out  = lane_ff;

endmodule // dvc_depth_reg

// File: logic/dvc_regs.sv
// dvc_regs: host register front end of the drawing engine: command upper
// fields, short vector pair, colour and plane mask registers.
// assumes host I/O strobes are one-cycle pulses synchronous to clk_in.
// Behaviour
// - byte order bit splits word accesses
// - decode command field into eight commands
// - vector draws length pixels, advances position
// - pixel-write bit gates marking only
// - direction code gives 45-degree steps
// - two vectors run in byte order
// - vector starts only on high byte write
// - zero length unmarked vector is no-op
// - source code 00 background, 01 foreground
// - 16bpp registers load via modulo-2 counter
// - 32bpp registers load via modulo-4 counter
// - counters clear on control, command, resets
// - each register has its own counter
// - three writes leave lane D unchanged
// - colour port read mid-command reads pixels
// - colour write routed to pixels when busy or data waiting and pixel-write enable set
// - write mask bit enables plane modification
// - read mask bit set hides plane
// - pixel port byte or ordered word
`timescale 1ns/1ps
module dvc_regs
    import dvc_pkg::*;
(
    input  wire logic        clk_in,                // 40 MHz engine clock
    input  wire logic        resetn_in,             // async reset, active low
    input  wire logic [15:0] io_addr_in,            // I/O word address
    input  wire logic        io_wr_in,              // write pulse
    input  wire logic        io_rd_in,              // read pulse
    input  wire logic [1:0]  io_be_in,              // byte lanes, [1] odd byte
    input  wire logic [15:0] io_wdata_in,           // write data
    output logic      [15:0] io_rdata_out,          // read data, next cycle
    input  wire logic [1:0]  depth_in,              // pixel depth code
    input  wire logic        engine_busy_flag_in,   // command running
    input  wire logic        pixel_data_ready_in,   // pixel data waiting
    input  wire logic        ext_ctl_one_wr_in,     // extended_control_one written
    input  wire logic        cmd_active_in,         // command became active
    input  wire logic        soft_reset_in,         // software reset pulse
    output logic             cmd_issue_out,         // command written pulse
    output logic      [2:0]  cmd_code_out,          // command code
    output logic      [7:0]  cmd_onehot_out,        // decoded command
    output logic             byte_order_select_out, // 1 low byte first
    output logic             word_transfer_mode_out,// 16-bit pixel port
    output logic             pixel_data_enable_out, // pixel port in use
    output logic             vec_valid_out,         // vector offered
    input  wire logic        vec_ready_in,          // vector taken
    output logic      [3:0]  vec_length_out,        // pixels and advance
    output logic             vec_pixel_write_out,   // mark pixels
    output logic      [2:0]  vec_direction_out,     // 45-degree code
    output logic      [1:0]  vec_step_x_out,        // signed x step
    output logic      [1:0]  vec_step_y_out,        // signed y step, down +
    output logic             pxt_wr_out,            // pixel port write pulse
    output logic             pxt_word_out,          // both bytes valid
    output logic      [15:0] pxt_wdata_out,         // first byte in [7:0]
    output logic             pxt_rd_out,            // pixel port read pulse
    input  wire logic [15:0] pxt_rdata_in,          // first byte in [7:0]
    input  wire logic        fore_mix_sel_in,       // foreground mix chosen
    input  wire logic [1:0]  fore_source_select_in, // foreground source
    input  wire logic [1:0]  back_source_select_in, // background source
    output logic      [31:0] src_colour_out,        // chosen colour
    output logic             src_is_colour_out,     // source is a colour reg
    output logic      [31:0] bg_colour_out,         // background colour
    output logic      [31:0] fg_colour_out,         // foreground colour
    output logic      [31:0] plane_write_en_out,    // 1 plane writable
    output logic      [31:0] plane_read_en_out      // 1 plane readable
);

    typedef enum logic [0:0] {
        VS_IDLE,
        VS_RUN
    } dvc_vs_t;

    localparam logic [15:0] VDR_ADDR [DVC_NUM_VDR] =
        '{DVC_ADDR_BG, DVC_ADDR_FG, DVC_ADDR_WMASK, DVC_ADDR_RMASK};

    function automatic logic is_colour_port(input logic [15:0] a);
        return (a == DVC_ADDR_BG) || (a == DVC_ADDR_FG);
    endfunction

    function automatic logic is_null_vec(input logic [7:0] v);
        return (v[DVC_VEC_LEN_LSB +: 4] == 4'h0) && !v[DVC_VEC_MARK_BIT];
    endfunction

    // with low_first set the host word already has its first byte low
    function automatic logic [15:0] order_bytes(input logic [15:0] w,
                                                input logic low_first);
        return low_first ? w : {w[7:0], w[15:8]};
    endfunction

    function automatic logic [31:0] depth_mask(input logic [1:0] d);
        case (d)
            DVC_DEPTH_16: return 32'h0000FFFF;
            DVC_DEPTH_32: return 32'hFFFFFFFF;
            default:      return 32'h000000FF;
        endcase
    endfunction

    // screen y grows downward, so counter-clockwise turns go up
    function automatic logic [3:0] dir_steps(input logic [2:0] d);
        case (d)
            3'h0:    return {2'h1, 2'h0};
            3'h1:    return {2'h1, 2'h3};
            3'h2:    return {2'h0, 2'h3};
            3'h3:    return {2'h3, 2'h3};
            3'h4:    return {2'h3, 2'h0};
            3'h5:    return {2'h3, 2'h1};
            3'h6:    return {2'h0, 2'h1};
            default: return {2'h1, 2'h1};
        endcase
    endfunction

    logic       cmd_hi_wr;
    logic       vec_hi_wr;
    logic       vec_lo_wr;
    logic       to_pxt;
    logic       cnt_clr;

    assign cmd_hi_wr = io_wr_in && io_be_in[1] && (io_addr_in == DVC_ADDR_CMD);
    assign vec_hi_wr = io_wr_in && io_be_in[1] && (io_addr_in == DVC_ADDR_VEC);
    assign vec_lo_wr = io_wr_in && io_be_in[0] && (io_addr_in == DVC_ADDR_VEC);
    assign cnt_clr   = ext_ctl_one_wr_in || cmd_active_in || soft_reset_in;

    // command register upper fields
    logic [2:0] cmd_code_ff;
    logic [2:0] nxt_cmd_code;
    logic       order_ff;
    logic       nxt_order;
    logic       word_ff;
    logic       nxt_word;
    logic       pxen_ff;
    logic       nxt_pxen;
    logic       issue_ff;
    logic       nxt_issue;

    always_comb begin
        nxt_cmd_code = cmd_code_ff;
        nxt_order    = order_ff;
        nxt_word     = word_ff;
        nxt_pxen     = pxen_ff;
        nxt_issue    = cmd_hi_wr;
        if (cmd_hi_wr) begin
            nxt_cmd_code = io_wdata_in[DVC_CMD_CODE_LSB +: 3];
            nxt_order    = io_wdata_in[DVC_CMD_ORDER_BIT];
            nxt_word     = io_wdata_in[DVC_CMD_WORD_BIT];
            nxt_pxen     = io_wdata_in[DVC_CMD_PXEN_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmd_code_ff <= DVC_CMD_RESET;
            order_ff    <= 1'b0;
            word_ff     <= 1'b0;
            pxen_ff     <= 1'b0;
            issue_ff    <= 1'b0;
        end else begin
            cmd_code_ff <= nxt_cmd_code;
            order_ff    <= nxt_order;
            word_ff     <= nxt_word;
            pxen_ff     <= nxt_pxen;
            issue_ff    <= nxt_issue;
        end
    end

    assign cmd_issue_out          = issue_ff;
    assign cmd_code_out           = cmd_code_ff;
    assign cmd_onehot_out         = 8'(8'h01 << cmd_code_ff);
    assign byte_order_select_out  = order_ff;
    assign word_transfer_mode_out = word_ff;
    assign pixel_data_enable_out  = pxen_ff;

    // short vector pair and sequencer
    dvc_vs_t     vs_ff;
    dvc_vs_t     nxt_vs;
    logic [15:0] vraw_ff;
    logic [15:0] nxt_vraw;
    logic [7:0]  cur_ff;
    logic [7:0]  nxt_cur;
    logic [7:0]  pend_ff;
    logic [7:0]  nxt_pend;
    logic        pv_ff;
    logic        nxt_pv;
    logic [7:0]  first_b;
    logic [7:0]  second_b;

    always_comb begin
        nxt_vraw = vraw_ff;
        nxt_vs   = vs_ff;
        nxt_cur  = cur_ff;
        nxt_pend = pend_ff;
        nxt_pv   = pv_ff;
        if (vec_lo_wr) begin
            nxt_vraw[7:0] = io_wdata_in[7:0];
        end
        if (vec_hi_wr) begin
            nxt_vraw[15:8] = io_wdata_in[15:8];
        end
        first_b  = order_ff ? nxt_vraw[7:0] : nxt_vraw[15:8];
        second_b = order_ff ? nxt_vraw[15:8] : nxt_vraw[7:0];
        case (vs_ff)
            VS_IDLE: begin
                // a low byte alone only stores; the high byte launches
                if (vec_hi_wr) begin
                    if (!is_null_vec(first_b)) begin
                        nxt_cur  = first_b;
                        nxt_pend = second_b;
                        nxt_pv   = !is_null_vec(second_b);
                        nxt_vs   = VS_RUN;
                    end else if (!is_null_vec(second_b)) begin
                        nxt_cur = second_b;
                        nxt_pv  = 1'b0;
                        nxt_vs  = VS_RUN;
                    end
                end
            end
            VS_RUN: begin
                // new pairs arriving mid-run are stored but not launched
                if (vec_ready_in) begin
                    if (pv_ff) begin
                        nxt_cur = pend_ff;
                        nxt_pv  = 1'b0;
                    end else begin
                        nxt_vs = VS_IDLE;
                    end
                end
            end
            default: nxt_vs = VS_IDLE;
        endcase
        if (soft_reset_in) begin
            nxt_vs = VS_IDLE;
            nxt_pv = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            vs_ff   <= VS_IDLE;
            vraw_ff <= DVC_VEC_RESET;
            cur_ff  <= DVC_VEC_RESET[7:0];
            pend_ff <= DVC_VEC_RESET[7:0];
            pv_ff   <= 1'b0;
        end else begin
            vs_ff   <= nxt_vs;
            vraw_ff <= nxt_vraw;
            cur_ff  <= nxt_cur;
            pend_ff <= nxt_pend;
            pv_ff   <= nxt_pv;
        end
    end

    // length is both pixel count and advance; mark bit gates writes only
    assign vec_valid_out       = (vs_ff == VS_RUN);
    assign vec_length_out      = cur_ff[DVC_VEC_LEN_LSB +: 4];
    assign vec_pixel_write_out = cur_ff[DVC_VEC_MARK_BIT];
    assign vec_direction_out   = cur_ff[DVC_VEC_DIR_LSB +: 3];
    assign {vec_step_x_out, vec_step_y_out} = dir_steps(cur_ff[DVC_VEC_DIR_LSB +: 3]);

    // colour and mask registers, one counter each
    logic [31:0] vdr_val  [DVC_NUM_VDR];
    logic [1:0]  vdr_lane [DVC_NUM_VDR];
    logic        vdr_wr   [DVC_NUM_VDR];

    assign to_pxt = (engine_busy_flag_in || pixel_data_ready_in) && pxen_ff;

    genvar gi;
    generate
        for (gi = 0; gi < DVC_NUM_VDR; gi++) begin : g_vdr
            // only the low byte lane carries register data
            assign vdr_wr[gi] = io_wr_in && io_be_in[0] && (io_addr_in == VDR_ADDR[gi]) &&
                                !(is_colour_port(io_addr_in) && to_pxt);
            dvc_depth_reg u_reg (
                .clk_in    (clk_in),
                .resetn_in (resetn_in),
                .clr_in    (cnt_clr),
                .wr_in     (vdr_wr[gi]),
                .byte_in   (io_wdata_in[7:0]),
                .depth_in  (depth_in),
                .value_out (vdr_val[gi]),
                .lane_out  (vdr_lane[gi])
            );
        end
    endgenerate

    assign bg_colour_out      = vdr_val[DVC_VDR_BG];
    assign fg_colour_out      = vdr_val[DVC_VDR_FG];
    assign plane_write_en_out = vdr_val[DVC_VDR_WM] & depth_mask(depth_in);
    assign plane_read_en_out  = ~vdr_val[DVC_VDR_RM] & depth_mask(depth_in);

    logic [1:0] src_sel;
    assign src_sel           = fore_mix_sel_in ? fore_source_select_in : back_source_select_in;
    assign src_is_colour_out = !src_sel[1];
    assign src_colour_out    = src_sel[0] ? vdr_val[DVC_VDR_FG] : vdr_val[DVC_VDR_BG];

    // host read data and pixel port
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        pxwr_ff;
    logic        nxt_pxwr;
    logic        pxword_ff;
    logic        nxt_pxword;
    logic [15:0] pxdat_ff;
    logic [15:0] nxt_pxdat;

    assign pxt_rd_out = io_rd_in && is_colour_port(io_addr_in) && engine_busy_flag_in;

    always_comb begin
        nxt_rdata  = rdata_ff;
        nxt_pxwr   = 1'b0;
        nxt_pxword = pxword_ff;
        nxt_pxdat  = pxdat_ff;
        if (io_rd_in) begin
            case (io_addr_in)
                DVC_ADDR_VEC:   nxt_rdata = vraw_ff;
                DVC_ADDR_WMASK: nxt_rdata = {8'h00, vdr_val[DVC_VDR_WM][7:0]};
                DVC_ADDR_RMASK: nxt_rdata = {8'h00, vdr_val[DVC_VDR_RM][7:0]};
                default:        nxt_rdata = 16'h0000;
            endcase
            if (pxt_rd_out) begin
                nxt_rdata = word_ff ? order_bytes(pxt_rdata_in, order_ff) :
                                      {pxt_rdata_in[7:0], pxt_rdata_in[7:0]};
            end
        end
        if (io_wr_in && is_colour_port(io_addr_in) && to_pxt) begin
            nxt_pxwr   = 1'b1;
            nxt_pxword = word_ff && (io_be_in == 2'b11);
            if (nxt_pxword) begin
                nxt_pxdat = order_bytes(io_wdata_in, order_ff);
            end else begin
                nxt_pxdat = {8'h00, io_be_in[0] ? io_wdata_in[7:0] : io_wdata_in[15:8]};
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_ff  <= 16'h0000;
            pxwr_ff   <= 1'b0;
            pxword_ff <= 1'b0;
            pxdat_ff  <= 16'h0000;
        end else begin
            rdata_ff  <= nxt_rdata;
            pxwr_ff   <= nxt_pxwr;
            pxword_ff <= nxt_pxword;
            pxdat_ff  <= nxt_pxdat;
        end
    end

    assign io_rdata_out  = rdata_ff;
    assign pxt_wr_out    = pxwr_ff;
    assign pxt_word_out  = pxword_ff;
    assign pxt_wdata_out = pxdat_ff;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_vec_idle_word_wr;
        vs_ff == VS_IDLE && io_wr_in && io_be_in == 2'b11 &&
        io_addr_in == DVC_ADDR_VEC && !soft_reset_in;
    endsequence

    sequence s_colour_to_pxt;
        io_wr_in && io_addr_in == DVC_ADDR_BG && engine_busy_flag_in && pxen_ff;
    endsequence

    property p_cmd_decode;
        cmd_hi_wr |=> cmd_issue_out && cmd_code_out == $past(io_wdata_in[15:13]) &&
                      cmd_onehot_out[$past(io_wdata_in[15:13])];
    endproperty
    a_cmd_decode: assert property (p_cmd_decode) else $error("command code not decoded");

    property p_lo_no_start;
        vs_ff == VS_IDLE && vec_lo_wr && !vec_hi_wr |=> !vec_valid_out;
    endproperty
    a_lo_no_start: assert property (p_lo_no_start) else $error("vector started on low byte");

    property p_null_pair;
        s_vec_idle_word_wr ##0 (is_null_vec(io_wdata_in[7:0]) && is_null_vec(io_wdata_in[15:8]))
            |=> !vec_valid_out;
    endproperty
    a_null_pair: assert property (p_null_pair) else $error("null vector pair executed");

    // the second vector only follows once the sink has taken the first
    property p_vec_order;
        s_vec_idle_word_wr ##0 (!order_ff && !is_null_vec(io_wdata_in[15:8]) && !is_null_vec(io_wdata_in[7:0]) &&
                                !vec_ready_in)
            |=> vec_valid_out && cur_ff == $past(io_wdata_in[15:8]) ##1
                (vec_valid_out && cur_ff == ($past(vec_ready_in) ? $past(io_wdata_in[7:0], 2) :
                                                                   $past(io_wdata_in[15:8], 2)));
    endproperty
    a_vec_order: assert property (p_vec_order) else $error("high byte vector not first");

    property p_dir_up;
        vec_valid_out && vec_direction_out == 3'h2 |-> vec_step_x_out == 2'h0 && vec_step_y_out == 2'h3;
    endproperty
    a_dir_up: assert property (p_dir_up) else $error("90 degree step wrong");

    property p_colour_route;
        s_colour_to_pxt |=> pxt_wr_out ##0 bg_colour_out == $past(bg_colour_out);
    endproperty
    a_colour_route: assert property (p_colour_route) else $error("busy colour write not routed");

    property p_pxt_read;
        io_rd_in && io_addr_in == DVC_ADDR_FG && engine_busy_flag_in && !word_ff
            |-> pxt_rd_out ##1 io_rdata_out[7:0] == $past(pxt_rdata_in[7:0]);
    endproperty
    a_pxt_read: assert property (p_pxt_read) else $error("colour port read missed pixel data");

    property p_cnt_clear;
        ext_ctl_one_wr_in |=> vdr_lane[DVC_VDR_BG] == 2'h0 && vdr_lane[DVC_VDR_RM] == 2'h0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("byte counter not cleared");

    property p_mod2;
        depth_in == DVC_DEPTH_16 && vdr_wr[DVC_VDR_FG] && vdr_lane[DVC_VDR_FG] == 2'h1 && !cnt_clr
            |=> vdr_lane[DVC_VDR_FG] == 2'h0 && fg_colour_out[15:8] == $past(io_wdata_in[7:0]);
    endproperty
    a_mod2: assert property (p_mod2) else $error("modulo-2 lane B load wrong");

    property p_own_counter;
        vdr_wr[DVC_VDR_BG] && !vdr_wr[DVC_VDR_WM] && !cnt_clr |=> $stable(vdr_lane[DVC_VDR_WM]);
    endproperty
    a_own_counter: assert property (p_own_counter) else $error("counter shared between registers");

endmodule // dvc_regs

// File: test/dvc_vec_sink.sv
// dvc_vec_sink: engine side that takes short vectors from the front end.
// assumes valid holds until taken; slow mode stalls every other cycle.
`timescale 1ns/1ps
module dvc_vec_sink (
    input  wire logic clk_in,   // engine clock
    input  wire logic valid_in, // vector offered
    input  wire logic slow_in,  // stall alternate cycles
    output logic      ready_out // vector taken
);
    always_ff @(posedge clk_in) begin
        ready_out <= valid_in && !(slow_in && ready_out);
    end
endmodule // dvc_vec_sink

// File: test/test_dvc_regs.sv
// test_dvc_regs: self-checking bench for the vector, colour and mask front end.
// assumes one 40 MHz clock and one host access at a time.
`timescale 1ns/1ps
module test_dvc_regs;
    import dvc_pkg::*;
    logic        clk_in = 0, resetn_in = 0, io_wr_in = 0, io_rd_in = 0, engine_busy_flag_in = 0, slow = 0;
    logic        pixel_data_ready_in = 0, fore_mix_sel_in = 1;
    logic [15:0] io_addr_in = 0, io_wdata_in = 0, pxt_rdata_in = 0, io_rdata_out, pxt_wdata_out;
    logic [1:0]  io_be_in = 0, depth_in = 2, fore_source_select_in = 0, back_source_select_in = 0;
    logic [2:0]  clr = 0, cmd_code_out, vec_direction_out;
    logic [7:0]  cmd_onehot_out, b[4], got[$];
    logic [3:0]  vec_length_out;
    logic [1:0]  vec_step_x_out, vec_step_y_out;
    logic [31:0] src_colour_out, bg_colour_out, fg_colour_out, plane_write_en_out, plane_read_en_out, eb, em;
    logic        cmd_issue_out, byte_order_select_out, word_transfer_mode_out, pixel_data_enable_out;
    logic        vec_valid_out, vec_ready_in, vec_pixel_write_out, pxt_wr_out, pxt_word_out, pxt_rd_out;
    logic        src_is_colour_out;
    wire         ext_ctl_one_wr_in = clr[0], cmd_active_in = clr[1], soft_reset_in = clr[2];
    int          miscompares = 0, comparisons = 0;

    dvc_regs u_dvc_regs (.*);
    dvc_vec_sink u_dvc_vec_sink (.clk_in, .valid_in(vec_valid_out), .slow_in(slow), .ready_out(vec_ready_in));

    initial forever #12.5 clk_in = ~clk_in;
    // whole run is under two hundred cycles
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end

    task automatic chk(input logic [31:0] s, x);
        comparisons++;
        if (s !== x) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic io(input logic w, input logic [15:0] a, input logic [1:0] e, input logic [15:0] d);
        @(posedge clk_in);
        #2;
        {io_wr_in, io_rd_in, io_addr_in, io_be_in, io_wdata_in} = {w, !w, a, e, d};
        @(posedge clk_in);
        #2;
        {io_wr_in, io_rd_in} = 0;
    endtask
    task automatic pulse(input logic [2:0] c);
        clr = c;
        @(posedge clk_in);
        #2 clr = 0;
    endtask
    // record each vector that is handed over, slow partner or not
    task automatic vecs(input logic [7:0] f, s, input int n);
        got = {};
        repeat (12) begin
            @(posedge clk_in);
            #2;
            if (vec_valid_out === 1'b1 && vec_ready_in === 1'b1)
                got.push_back({vec_direction_out, vec_pixel_write_out, vec_length_out});
        end
        chk(got.size(), n);
        if (n > 0) chk(got[0], f);
        if (n > 1) chk(got[1], s);
        $display("vector pair done");
    endtask
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        void'($urandom(25122));
        repeat (6) @(posedge clk_in);
        #2 resetn_in = 1;
        chk(plane_read_en_out, 32'h0000FFFF);
        depth_in = 1; // outline and fill codes only issued at shallow depth
        for (int c = 0; c < 8; c++) begin
            io(1, DVC_ADDR_CMD, 2'h2, {c[2:0], 13'h1300});
            chk(cmd_onehot_out, 32'h1 << c);
        end
        chk(byte_order_select_out, 1);
        $display("command decode done");
        depth_in = 2;
        for (int k = 0; k < 3; k++) begin
            b[0] = 8'($urandom);
            b[1] = 8'($urandom);
            io(1, DVC_ADDR_BG, 2'h1, 16'h005A);
            pulse(3'h1 << k);
            io(1, DVC_ADDR_BG, 2'h1, {8'h00, b[0]});
            io(1, DVC_ADDR_FG, 2'h1, {8'h00, b[1]});
            io(1, DVC_ADDR_BG, 2'h1, {8'h00, b[1]});
            io(1, DVC_ADDR_FG, 2'h1, {8'h00, b[0]});
            chk(fg_colour_out[15:0], {b[0], b[1]});
            eb = {16'h0000, b[1], b[0]};
            chk(bg_colour_out, eb);
            chk(fg_colour_out[7:0], b[1]);
        end
        for (int s = 0; s < 4; s++) begin
            fore_mix_sel_in = s[1];
            fore_source_select_in = {1'b0, s[0]};
            back_source_select_in = {1'b0, !s[0]};
            #1 chk(src_colour_out[7:0], (s[1] ^ s[0]) ? b[0] : b[1]);
        end
        $display("colour lanes done");
        depth_in = 3;
        for (int i = 0; i < 4; i++) begin
            em = {8'($urandom), em[31:8]};
            io(1, DVC_ADDR_WMASK, 2'h1, {8'h00, em[31:24]});
        end
        chk(plane_write_en_out, em);
        for (int i = 0; i < 3; i++) begin
            b[i] = 8'($urandom);
            io(1, DVC_ADDR_WMASK, 2'h1, {8'h00, b[i]});
        end
        chk(plane_write_en_out, {em[31:24], b[2], b[1], b[0]});
        pulse(3'h2);
        io(1, DVC_ADDR_WMASK, 2'h1, 16'h00A5);
        chk(plane_write_en_out, {em[31:24], b[2], b[1], 8'hA5});
        io(0, DVC_ADDR_WMASK, 2'h1, 16'h0000);
        chk(io_rdata_out, 16'h00A5);
        depth_in = 1;
        b[0] = 8'hFF >> $urandom_range(7, 0); // readable planes kept contiguous
        io(1, DVC_ADDR_RMASK, 2'h1, {8'h00, b[0]});
        chk(plane_read_en_out, {24'h0, ~b[0]});
        chk(plane_write_en_out, 32'h000000A5);
        $display("mask lanes done");
        io(1, DVC_ADDR_CMD, 2'h2, 16'h0300);
        for (int r = 0; r < 2; r++) begin
            slow = r[0];
            b[0] = {3'(r * 5 + 2), 1'b1, 4'($urandom_range(15, 1))};
            b[1] = r ? 8'h00 : (8'($urandom) | 8'h01);
            io(1, DVC_ADDR_VEC, 2'h1, {8'h00, b[1]});
            chk(vec_valid_out, 0);
            io(1, DVC_ADDR_VEC, 2'h2, {b[0], 8'h00});
            vecs(b[0], b[1], 2 - r);
        end
        b[1] = 8'($urandom) | 8'h01;
        io(1, DVC_ADDR_VEC, 2'h3, {b[0], b[1]});
        vecs(b[0], b[1], 2);
        io(1, DVC_ADDR_VEC, 2'h3, 16'hE0A0);
        vecs(8'h00, 8'h00, 0);
        engine_busy_flag_in = 1;
        b[0] = 8'($urandom);
        b[1] = 8'($urandom);
        io(1, DVC_ADDR_BG, 2'h3, {b[1], b[0]});
        chk({pxt_wr_out, pxt_word_out, pxt_wdata_out}, {2'h3, b[0], b[1]});
        chk(bg_colour_out, eb);
        pxt_rdata_in = 16'($urandom);
        io(0, DVC_ADDR_FG, 2'h3, 16'h0000);
        chk(io_rdata_out, {pxt_rdata_in[7:0], pxt_rdata_in[15:8]});
        $display("pixel port done");
        give_verdict();
    end
endmodule // test_dvc_regs
